/* design/flash_erase_defines.svh */
// Opcodes, status layout, address fields and timing counts of the erase link
`ifndef FLASH_ERASE_DEFINES_SVH
`define FLASH_ERASE_DEFINES_SVH
// ==========================================================================
// Opcodes
`define OP_WR_ENABLE 8'h06
`define OP_WR_DISABLE 8'h04
`define OP_READ_STAT 8'h05
`define OP_PAGE_PROG 8'h02
`define OP_SECTOR_ERASE 8'h20
`define OP_BLK32_ERASE 8'h52
`define OP_BLK64_ERASE 8'hd8
`define OP_CHIP_ERASE_A 8'hc7
`define OP_CHIP_ERASE_B 8'h60
`define OP_SUSPEND 8'h75
`define OP_RESUME 8'h7a
// ==========================================================================
// Status byte and address fields
`define STAT_BUSY_BIT 0
`define FLASH_TOP_BIT 22
`define BLK64_LSB 16
`define BLK32_LSB 15
`define SECTOR_LSB 12
`define PAGE_LSB 8
`define PROT_LIMIT 8'h80
// ==========================================================================
// Timing
`define CLK_MHZ 64'd100
`define PAGE_PROG_TIME_US 64'd600
`define SECTOR_ERASE_TIME_US 64'd50000
`define BLK32_ERASE_TIME_US 64'd150000
`define BLK64_ERASE_TIME_US 64'd250000
`define CHIP_ERASE_TIME_S 64'd25
`define PAGE_PROG_CYCLES 32'(`PAGE_PROG_TIME_US * `CLK_MHZ)
`define SECTOR_ERASE_CYCLES 32'(`SECTOR_ERASE_TIME_US * `CLK_MHZ)
`define BLK32_ERASE_CYCLES 32'(`BLK32_ERASE_TIME_US * `CLK_MHZ)
`define BLK64_ERASE_CYCLES 32'(`BLK64_ERASE_TIME_US * `CLK_MHZ)
`define CHIP_ERASE_CYCLES 32'(`CHIP_ERASE_TIME_S * 64'd1000000 * `CLK_MHZ)
`define SCLK_HALF_CYCLES 8
`define CS_HIGH_NS 20
`define CS_HIGH_CYCLES ((`CS_HIGH_NS + 9) / 10)
`endif

/* design/flash_erase_pkg.sv */
// Types shared by both ends of the erase link
`default_nettype none
package flash_erase_pkg;
  // ==========
  // Operation kinds
  typedef enum logic [2:0] {
    OPK_NONE = 3'b000,
    OPK_PAGE = 3'b001,
    OPK_SECTOR = 3'b010,
    OPK_BLK32 = 3'b011,
    OPK_BLK64 = 3'b100,
    OPK_CHIP = 3'b101
  } op_kind_t;
  // ==========
  // Host sequencer and frame engine states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_POLL = 3'b001,
    H_WREN = 3'b010,
    H_CMD = 3'b011
  } host_seq_t;
  typedef enum logic [2:0] {
    F_IDLE = 3'b000,
    F_LEAD = 3'b001,
    F_LOW = 3'b010,
    F_HIGH = 3'b011,
    F_TAIL = 3'b100,
    F_GAP = 3'b101
  } frame_st_t;
endpackage : flash_erase_pkg
`default_nettype wire

/* design/flash_link_if.sv */
// Serial link between host controller and flash command logic
`default_nettype none
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic si;
  logic so;
  modport host (output cs_n, output sclk, output si, input so);
  modport dev (input cs_n, input sclk, input si, output so);
endinterface : flash_link_if
`default_nettype wire

/* design/flash_erase_dev.sv */
// Flash-side command logic for erase, program timing, suspend and resume
`include "flash_erase_defines.svh"
`default_nettype none
// Notes on behaviour
// RULE1: 52h plus three address bytes decodes 32KB erase
// RULE2: Host sets write latch before any erase
// RULE3: Any address erases its whole 32KB block
// RULE4: 32KB erase only if select rises after byte four
// RULE5: Self-timed erase, busy set, latch cleared early
// RULE6: Protected 32KB block is never erased
// RULE7: D8h plus address erases containing 64KB block
// RULE8: 64KB erase dropped unless exact byte count
// RULE9: Protected 64KB block is refused
// RULE10: C7h or 60h alone means chip erase
// RULE11: Chip erase needs write latch set
// RULE12: Chip erase only after exactly eight bits
// RULE13: Chip erase busy, status readable, latch cleared
// RULE14: Chip erase only with zero protection level
// RULE15: 75h suspends sector, block or page operation
// RULE16: Erase suspend rejects listed erase opcodes; 52h is still accepted while an erase is suspended
// RULE17: Suspend ignored during chip erase
// RULE18: Program suspend rejects program; page only
// RULE19: Resume only when suspended and not busy
// RULE20: Resume clears suspended, sets busy, finishes
// RULE21: 20h plus address erases its 4KB sector
// RULE22: Host polls busy before other instructions
module flash_erase_dev #(
  parameter logic [31:0] PAGE_CYCLES = `PAGE_PROG_CYCLES,
  parameter logic [31:0] SECTOR_CYCLES = `SECTOR_ERASE_CYCLES,
  parameter logic [31:0] BLK32_CYCLES = `BLK32_ERASE_CYCLES,
  parameter logic [31:0] BLK64_CYCLES = `BLK64_ERASE_CYCLES,
  parameter logic [31:0] CHIP_CYCLES = `CHIP_ERASE_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  flash_link_if.dev link,
  input wire logic [4:0] i_protect_level_bits,
  output logic o_busy_flag,
  output logic o_write_latch_flag,
  output logic o_suspended_flag,
  output flash_erase_pkg::op_kind_t o_op_kind,
  output logic [23:0] o_op_base,
  output logic o_op_start,
  output logic o_op_done
);
  // ==========
  // Elaboration checks
  if (PAGE_CYCLES < 32'h2 || SECTOR_CYCLES < 32'h2 || BLK32_CYCLES < 32'h2 ||
      BLK64_CYCLES < 32'h2 || CHIP_CYCLES < 32'h2) begin : g_bad_cycles
    $error("operation cycle counts must be at least two");
  end

  // ==========
  // State
  typedef struct packed {
    logic [1:0] cs_s;
    logic [1:0] ck_s;
    logic [1:0] si_s;
    logic cs_prev;
    logic ck_prev;
    logic [2:0] bitpos;
    logic [3:0] bytes;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [23:0] addr;
    logic [7:0] tx;
    logic so;
    logic busy;
    logic write_latch_flag;
    logic suspended_flag;
    flash_erase_pkg::op_kind_t kind;
    flash_erase_pkg::op_kind_t sus_kind;
    logic [31:0] timer;
    logic [31:0] sus_timer;
    logic [23:0] base;
    logic [23:0] sus_base;
    logic op_start;
    logic op_done;
  } dev_state_t;

  dev_state_t q;
  dev_state_t d;

  logic ck_rise;
  logic ck_fall;
  logic cs_rise;
  logic [7:0] next_byte;
  logic [7:0] status;
  logic erase_sus;
  logic prog_sus;

  assign ck_rise = q.ck_s[1] & ~q.ck_prev;
  assign ck_fall = ~q.ck_s[1] & q.ck_prev;
  assign cs_rise = q.cs_s[1] & ~q.cs_prev;
  assign next_byte = {q.shift[6:0], q.si_s[1]};
  // Busy in bit 0, latch bit 1, level bits 6:2, suspended bit 7
  assign status = {q.suspended_flag, i_protect_level_bits, q.write_latch_flag, q.busy};
  assign erase_sus = q.suspended_flag && (q.sus_kind != flash_erase_pkg::OPK_PAGE);
  assign prog_sus = q.suspended_flag && (q.sus_kind == flash_erase_pkg::OPK_PAGE);

  // ==========
  // Helpers
  function automatic logic is_prot(input logic [23:0] a, input logic [4:0] lvl);
    logic [7:0] sum;
    sum = {1'b0, a[`FLASH_TOP_BIT:`BLK64_LSB]} + {3'b000, lvl};
    // Level counts protected 64KB blocks down from the top of the array
    return (lvl != 5'h00) && (sum >= `PROT_LIMIT);
  endfunction : is_prot

  function automatic logic [31:0] dur(input flash_erase_pkg::op_kind_t k);
    unique case (k)
      flash_erase_pkg::OPK_PAGE: return PAGE_CYCLES;
      flash_erase_pkg::OPK_SECTOR: return SECTOR_CYCLES;
      flash_erase_pkg::OPK_BLK32: return BLK32_CYCLES;
      flash_erase_pkg::OPK_BLK64: return BLK64_CYCLES;
      default: return CHIP_CYCLES;
    endcase
  endfunction : dur

  function automatic logic [23:0] align(input flash_erase_pkg::op_kind_t k, input logic [23:0] a);
    unique case (k)
      flash_erase_pkg::OPK_PAGE: return a & ~((24'h1 << `PAGE_LSB) - 24'h1);
      flash_erase_pkg::OPK_SECTOR: return a & ~((24'h1 << `SECTOR_LSB) - 24'h1); // RULE21
      flash_erase_pkg::OPK_BLK32: return a & ~((24'h1 << `BLK32_LSB) - 24'h1); // RULE3
      flash_erase_pkg::OPK_BLK64: return a & ~((24'h1 << `BLK64_LSB) - 24'h1); // RULE7
      default: return 24'h000000;
    endcase
  endfunction : align

  // ==========
  // Next state
  always_comb begin
    flash_erase_pkg::op_kind_t k;
    logic go;
    k = flash_erase_pkg::OPK_NONE;
    go = 1'b0;
    d = q;
    d.op_start = 1'b0;
    d.op_done = 1'b0;
    d.cs_s = {q.cs_s[0], link.cs_n};
    d.ck_s = {q.ck_s[0], link.sclk};
    d.si_s = {q.si_s[0], link.si};
    d.cs_prev = q.cs_s[1];
    d.ck_prev = q.ck_s[1];
    // Self-timed cycle
    if (q.busy) begin
      if (q.timer <= 32'h1) begin
        d.busy = 1'b0; // RULE5
        d.op_done = 1'b1;
        d.kind = flash_erase_pkg::OPK_NONE;
        if (q.kind == flash_erase_pkg::OPK_CHIP) begin
          d.write_latch_flag = 1'b0; // RULE13
        end
      end else begin
        d.timer = q.timer - 32'h1;
      end
    end
    // Shift in on rising, out on falling; status stays readable while busy
    if (!q.cs_s[1]) begin
      if (ck_rise) begin
        d.shift = next_byte;
        d.bitpos = q.bitpos + 3'h1;
        if (q.bitpos == 3'h7) begin
          if (q.bytes != 4'hf) begin
            d.bytes = q.bytes + 4'h1;
          end
          if (q.bytes == 4'h0) begin
            d.opcode = next_byte;
          end else if (q.bytes < 4'h4) begin
            d.addr = {q.addr[15:0], next_byte};
          end
          if ((q.bytes == 4'h0 && next_byte == `OP_READ_STAT) ||
              (q.bytes != 4'h0 && q.opcode == `OP_READ_STAT)) begin
            d.tx = status; // RULE13
          end
        end
      end
      if (ck_fall) begin
        d.so = q.tx[7];
        d.tx = {q.tx[6:0], 1'b0};
      end
    end else begin
      d.bitpos = 3'h0;
      d.bytes = 4'h0;
      d.so = 1'b0;
    end
    // Decode at select rise; only whole-byte frames count
    if (cs_rise && q.bitpos == 3'h0) begin
      unique case (q.opcode)
        `OP_WR_ENABLE: begin
          if (q.bytes == 4'h1 && !q.busy) begin
            d.write_latch_flag = 1'b1;
          end
        end
        `OP_WR_DISABLE: begin
          if (q.bytes == 4'h1 && !q.busy) begin
            d.write_latch_flag = 1'b0;
          end
        end
        `OP_SUSPEND: begin
          // Chip erase and a cycle ending now are not suspended
          if (q.bytes == 4'h1 && q.busy && !q.suspended_flag && q.timer > 32'h1 &&
              q.kind != flash_erase_pkg::OPK_CHIP) begin // RULE17 RULE18
            d.suspended_flag = 1'b1; // RULE15
            d.sus_kind = q.kind;
            d.sus_timer = q.timer;
            d.sus_base = q.base;
            d.busy = 1'b0;
            d.kind = flash_erase_pkg::OPK_NONE;
          end
        end
        `OP_RESUME: begin
          if (q.bytes == 4'h1 && q.suspended_flag && !q.busy) begin // RULE19
            d.suspended_flag = 1'b0; // RULE20
            d.busy = 1'b1;
            d.kind = q.sus_kind;
            d.timer = q.sus_timer;
            d.base = q.sus_base;
          end
        end
        `OP_SECTOR_ERASE: begin
          k = flash_erase_pkg::OPK_SECTOR;
          go = (q.bytes == 4'h4) && !erase_sus; // RULE21 RULE16
        end
        `OP_BLK32_ERASE: begin
          k = flash_erase_pkg::OPK_BLK32;
          go = (q.bytes == 4'h4); // RULE1 RULE4
        end
        `OP_BLK64_ERASE: begin
          k = flash_erase_pkg::OPK_BLK64;
          go = (q.bytes == 4'h4) && !erase_sus; // RULE7 RULE8 RULE16
        end
        `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B: begin
          k = flash_erase_pkg::OPK_CHIP;
          // A suspended operation would be lost under a chip erase
          go = (q.bytes == 4'h1) && !q.suspended_flag && (i_protect_level_bits == 5'h00); // RULE10 RULE12 RULE14 RULE16
        end
        `OP_PAGE_PROG: begin
          k = flash_erase_pkg::OPK_PAGE;
          go = (q.bytes >= 4'h5) && !prog_sus; // RULE18
        end
        default: begin
          go = 1'b0;
        end
      endcase
      if (k != flash_erase_pkg::OPK_CHIP && is_prot(q.addr, i_protect_level_bits)) begin
        go = 1'b0; // RULE6 RULE9
      end
      if (go && q.write_latch_flag && !q.busy) begin // RULE2 RULE11
        d.busy = 1'b1; // RULE5
        d.kind = k;
        d.timer = dur(k);
        d.base = align(k, q.addr);
        d.op_start = 1'b1;
        if (k != flash_erase_pkg::OPK_CHIP) begin
          d.write_latch_flag = 1'b0; // RULE5
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q <= '{cs_s: 2'h3, cs_prev: 1'b1, kind: flash_erase_pkg::OPK_NONE,
             sus_kind: flash_erase_pkg::OPK_NONE, default: '0};
    end else begin
      q <= d;
    end
  end

  // ==========
  // Outputs
  assign link.so = q.so;
  assign o_busy_flag = q.busy;
  assign o_write_latch_flag = q.write_latch_flag;
  assign o_suspended_flag = q.suspended_flag;
  assign o_op_kind = q.kind;
  assign o_op_base = q.base;
  assign o_op_start = q.op_start;
  assign o_op_done = q.op_done;
endmodule : flash_erase_dev
`default_nettype wire

/* design/flash_erase_host.sv */
// Host controller end: frames commands, enables writes and polls busy
`include "flash_erase_defines.svh"
`default_nettype none
module flash_erase_host #(
  parameter int SCLK_HALF = `SCLK_HALF_CYCLES,
  parameter int CS_GAP = `CS_HIGH_CYCLES
) (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  flash_link_if.host link,
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_opcode,
  input wire logic [23:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_status
);
  // ==========
  // Elaboration checks
  if (SCLK_HALF < 4 || SCLK_HALF > 255 || CS_GAP < 1 || CS_GAP > 255) begin : g_bad_timing
    $error("serial clock half period must be 4..255 and gap 1..255");
  end

  localparam logic [7:0] HALF_M1 = 8'(SCLK_HALF - 1);
  localparam logic [7:0] GAP_M1 = 8'(CS_GAP - 1);

  // ==========
  // State
  typedef struct packed {
    flash_erase_pkg::host_seq_t seq;
    flash_erase_pkg::frame_st_t fr;
    logic [7:0] op;
    logic [23:0] addr;
    logic [7:0] data;
    logic [39:0] tx;
    logic [5:0] nbits;
    logic [5:0] bits;
    logic [7:0] cnt;
    logic [7:0] rx;
    logic [1:0] so_s;
    logic cs_n;
    logic sclk;
    logic si;
    logic ready;
    logic rsp;
    logic [7:0] status;
  } host_state_t;

  host_state_t q;
  host_state_t d;

  logic frame_done;
  assign frame_done = (q.fr == flash_erase_pkg::F_GAP) && (q.cnt == 8'h00);

  function automatic logic [5:0] frame_bits(input logic [7:0] op);
    unique case (op)
      `OP_READ_STAT: return 6'd16;
      `OP_SECTOR_ERASE, `OP_BLK32_ERASE, `OP_BLK64_ERASE: return 6'd32;
      `OP_PAGE_PROG: return 6'd40;
      default: return 6'd8;
    endcase
  endfunction : frame_bits

  function automatic logic is_write(input logic [7:0] op);
    return op == `OP_SECTOR_ERASE || op == `OP_BLK32_ERASE || op == `OP_BLK64_ERASE ||
           op == `OP_CHIP_ERASE_A || op == `OP_CHIP_ERASE_B || op == `OP_PAGE_PROG;
  endfunction : is_write

  // ==========
  // Next state
  always_comb begin
    logic [7:0] fop;
    logic launch;
    fop = 8'h00;
    launch = 1'b0;
    d = q;
    d.rsp = 1'b0;
    d.so_s = {q.so_s[0], link.so};
    // Frame engine, serial clock idles low
    unique case (q.fr)
      flash_erase_pkg::F_IDLE: begin
        d.cs_n = 1'b1;
      end
      flash_erase_pkg::F_LEAD, flash_erase_pkg::F_LOW: begin
        if (q.cnt == 8'h00) begin
          d.fr = flash_erase_pkg::F_HIGH;
          d.sclk = 1'b1;
          d.rx = {q.rx[6:0], q.so_s[1]};
          d.bits = q.bits + 6'h1;
          d.cnt = HALF_M1;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      flash_erase_pkg::F_HIGH: begin
        if (q.cnt == 8'h00) begin
          d.sclk = 1'b0;
          d.cnt = HALF_M1;
          if (q.bits == q.nbits) begin
            d.fr = flash_erase_pkg::F_TAIL;
          end else begin
            d.fr = flash_erase_pkg::F_LOW;
            d.si = q.tx[38];
            d.tx = {q.tx[38:0], 1'b0};
          end
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      flash_erase_pkg::F_TAIL: begin
        if (q.cnt == 8'h00) begin
          // Select rises only on a whole byte boundary
          d.fr = flash_erase_pkg::F_GAP; // RULE4 RULE12
          d.cs_n = 1'b1;
          d.cnt = GAP_M1;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      flash_erase_pkg::F_GAP: begin
        if (q.cnt == 8'h00) begin
          d.fr = flash_erase_pkg::F_IDLE;
        end else begin
          d.cnt = q.cnt - 8'h01;
        end
      end
      default: begin
        d.fr = flash_erase_pkg::F_IDLE;
      end
    endcase
    // Command sequencer
    unique case (q.seq)
      flash_erase_pkg::H_IDLE: begin
        if (i_cmd_valid && q.ready) begin
          d.ready = 1'b0;
          d.op = i_cmd_opcode;
          d.addr = i_cmd_addr;
          d.data = i_cmd_data;
          launch = 1'b1;
          if (i_cmd_opcode != `OP_READ_STAT && i_cmd_opcode != `OP_SUSPEND) begin
            d.seq = flash_erase_pkg::H_POLL; // RULE22
            fop = `OP_READ_STAT;
          end else begin
            d.seq = flash_erase_pkg::H_CMD;
            fop = i_cmd_opcode;
          end
        end
      end
      flash_erase_pkg::H_POLL: begin
        if (frame_done) begin
          launch = 1'b1;
          if (q.rx[`STAT_BUSY_BIT]) begin
            fop = `OP_READ_STAT; // RULE22
          end else if (is_write(q.op)) begin
            d.seq = flash_erase_pkg::H_WREN; // RULE2
            fop = `OP_WR_ENABLE;
          end else begin
            d.seq = flash_erase_pkg::H_CMD;
            fop = q.op;
          end
        end
      end
      flash_erase_pkg::H_WREN: begin
        if (frame_done) begin
          launch = 1'b1;
          d.seq = flash_erase_pkg::H_CMD;
          fop = q.op;
        end
      end
      flash_erase_pkg::H_CMD: begin
        if (frame_done) begin
          d.seq = flash_erase_pkg::H_IDLE;
          d.ready = 1'b1;
          d.rsp = 1'b1;
          d.status = q.rx;
        end
      end
      default: begin
        d.seq = flash_erase_pkg::H_IDLE;
      end
    endcase
    if (launch) begin
      d.fr = flash_erase_pkg::F_LEAD;
      d.cs_n = 1'b0;
      d.sclk = 1'b0;
      d.cnt = HALF_M1;
      d.bits = 6'h00;
      d.nbits = frame_bits(fop);
      d.tx = {fop, d.addr, d.data}; // RULE1 RULE7 RULE10
      d.si = fop[7];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      q <= '{seq: flash_erase_pkg::H_IDLE, fr: flash_erase_pkg::F_IDLE, cs_n: 1'b1, ready: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // ==========
  // Outputs
  assign link.cs_n = q.cs_n;
  assign link.sclk = q.sclk;
  assign link.si = q.si;
  assign o_cmd_ready = q.ready;
  assign o_rsp_valid = q.rsp;
  assign o_rsp_status = q.status;
endmodule : flash_erase_host
`default_nettype wire

/* testbench/flash_erase_monitor.sv */
// Checker of the erase link wires and the device flags
`default_nettype none
module flash_erase_monitor (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic si,
  input wire logic so,
  input wire logic o_busy_flag,
  input wire logic o_write_latch_flag,
  input wire logic o_suspended_flag,
  input wire flash_erase_pkg::op_kind_t o_op_kind,
  input wire logic [23:0] o_op_base,
  input wire logic o_op_start,
  input wire logic o_op_done
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Link framing
  default clocking dc @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  property p_sclk_idle;
    cs_n |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk high while deselected");
  property p_si_steady;
    sclk && $past(sclk) |-> $stable(si);
  endproperty
  a_si_steady: assert property (p_si_steady) else $error("si moved while sclk high");
  // Six cycles covers the device's sync and output flop
  property p_so_quiet;
    cs_n && $past(cs_n, 6) |-> !so;
  endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("so driven while deselected");
  // ====================
  // Operation flags
  property p_start;
    o_op_start |-> $past(cs_n, 3) ##0 o_busy_flag [*8];
  endproperty
  a_start: assert property (p_start) else $error("start without select rise or busy");
  property p_start_wel;
    o_op_start && !$past(o_suspended_flag) |-> $past(o_write_latch_flag)
      && (o_op_kind == flash_erase_pkg::OPK_CHIP || !o_write_latch_flag);
  endproperty
  a_start_wel: assert property (p_start_wel) else $error("write latch wrong at start");
  property p_done;
    o_op_done |-> !o_busy_flag ##1 !o_op_done;
  endproperty
  a_done: assert property (p_done) else $error("done pulse without busy clear");
  property p_chip_end;
    $fell(o_busy_flag) && $past(o_op_kind) == flash_erase_pkg::OPK_CHIP |-> !o_write_latch_flag && !o_suspended_flag;
  endproperty
  a_chip_end: assert property (p_chip_end) else $error("chip erase ended badly");
  property p_blk32_base;
    o_busy_flag && o_op_kind == flash_erase_pkg::OPK_BLK32 |-> o_op_base[14:0] == 15'h0000;
  endproperty
  a_blk32_base: assert property (p_blk32_base) else $error("32KB base not aligned");
  property p_blk64_base;
    o_busy_flag && o_op_kind == flash_erase_pkg::OPK_BLK64 |-> o_op_base[15:0] == 16'h0000;
  endproperty
  a_blk64_base: assert property (p_blk64_base) else $error("64KB base not aligned");
  property p_suspend;
    $rose(o_suspended_flag) |-> !o_busy_flag && $past(o_busy_flag) && $past(o_op_kind) != flash_erase_pkg::OPK_CHIP;
  endproperty
  a_suspend: assert property (p_suspend) else $error("bad suspend");
  // Busy must return within 200 ns at 100 MHz
  property p_resume;
    $fell(o_suspended_flag) |-> !$past(o_busy_flag) ##[0:20] o_busy_flag;
  endproperty
  a_resume: assert property (p_resume) else $error("bad resume");
  c_chip: cover property (o_op_start && o_op_kind == flash_erase_pkg::OPK_CHIP);
  c_suspend: cover property ($rose(o_suspended_flag));
  c_resume: cover property ($fell(o_suspended_flag));
endmodule : flash_erase_monitor
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench: host and device ends joined over the link
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // Signals and tables
  localparam logic [31:0] OP_CYC = 32'h000003e8;
  logic i_clk_sys, i_srst, cmd_valid, cmd_ready, rsp_valid;
  logic [7:0] cmd_op, rsp_status;
  logic [23:0] cmd_addr, base;
  logic [4:0] prot;
  logic busy, write_latch_flag, suspended_flag, start, done, start2, prev_sclk, prev_cs;
  logic [39:0] wire_sr;
  flash_erase_pkg::op_kind_t kind;
  int fails, checked, cycles, starts, starts2, nbits, n;
  logic [7:0] prot_op [4] = '{8'h52, 8'hd8, 8'hc7, 8'h60};
  logic [23:0] prot_addr [4] = '{24'h7f9abc, 24'h7f0123, 24'h000000, 24'h000000};
  logic [7:0] sus_op [4] = '{8'h02, 8'h20, 8'hd8, 8'h52};
  logic [23:0] sus_addr [4] = '{24'h0012c4, 24'h054321, 24'h3acdef, 24'h019999};
  logic [23:0] sus_base [4] = '{24'h001200, 24'h054000, 24'h3a0000, 24'h018000};
  flash_erase_pkg::op_kind_t sus_kind [4] = '{flash_erase_pkg::OPK_PAGE, flash_erase_pkg::OPK_SECTOR,
    flash_erase_pkg::OPK_BLK64, flash_erase_pkg::OPK_BLK32};
  logic [7:0] rej_op [4] = '{8'h20, 8'hd8, 8'h60, 8'hc7};
  logic [39:0] f_bits [3] = '{40'h0000521234, 40'hd812345678, 40'h00000000c1};
  int f_len [3] = '{24, 40, 9};
  flash_link_if link ();
  flash_link_if link2 ();
  flash_erase_host flash_erase_host_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .link(link.host),
    .i_cmd_valid(cmd_valid), .i_cmd_opcode(cmd_op), .i_cmd_addr(cmd_addr), .i_cmd_data(8'h5a),
    .o_cmd_ready(cmd_ready), .o_rsp_valid(rsp_valid), .o_rsp_status(rsp_status));
  flash_erase_dev #(.PAGE_CYCLES(OP_CYC), .SECTOR_CYCLES(OP_CYC), .BLK32_CYCLES(OP_CYC), .BLK64_CYCLES(OP_CYC),
    .CHIP_CYCLES(OP_CYC)) flash_erase_dev_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .link(link.dev),
    .i_protect_level_bits(prot), .o_busy_flag(busy), .o_write_latch_flag(write_latch_flag), .o_suspended_flag(suspended_flag),
    .o_op_kind(kind), .o_op_base(base), .o_op_start(start), .o_op_done(done));
  // Second device faces a deliberately misbehaving host
  flash_erase_dev #(.PAGE_CYCLES(OP_CYC), .SECTOR_CYCLES(OP_CYC), .BLK32_CYCLES(OP_CYC), .BLK64_CYCLES(OP_CYC),
    .CHIP_CYCLES(OP_CYC)) flash_erase_dev_fault_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .link(link2.dev),
    .i_protect_level_bits(5'h00), .o_busy_flag(), .o_write_latch_flag(), .o_suspended_flag(),
    .o_op_kind(), .o_op_base(), .o_op_start(start2), .o_op_done());
  flash_erase_monitor flash_erase_monitor_i (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .cs_n(link.cs_n),
    .sclk(link.sclk), .si(link.si), .so(link.so), .o_busy_flag(busy), .o_write_latch_flag(write_latch_flag),
    .o_suspended_flag(suspended_flag), .o_op_kind(kind), .o_op_base(base), .o_op_start(start), .o_op_done(done));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Counts starts and records the last frame seen on the wire
  always @(posedge i_clk_sys) begin
    cycles <= cycles + 1;
    starts <= starts + int'(start);
    starts2 <= starts2 + int'(start2);
    prev_sclk <= link.sclk;
    prev_cs <= link.cs_n;
    if (prev_cs && !link.cs_n) begin
      nbits <= 0;
    end else if (link.sclk && !prev_sclk) begin
      wire_sr <= {wire_sr[38:0], link.si};
      nbits <= nbits + 1;
    end
  end
  // ====================
  // Tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked = checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  // Hangs are caught by the cycle ceiling
  task automatic cmd(input logic [7:0] op, input logic [23:0] addr);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= addr;
    @(posedge i_clk_sys);
    while (cmd_ready !== 1'b1) @(posedge i_clk_sys);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1) @(posedge i_clk_sys);
    repeat (6) @(posedge i_clk_sys);
  endtask : cmd
  task automatic wait_idle();
    while (busy !== 1'b0) @(posedge i_clk_sys);
    repeat (2) @(posedge i_clk_sys);
  endtask : wait_idle
  // Released data line flips so a stale bit is never read as valid
  task automatic raw_frame(input logic [39:0] bits, input int len);
    link2.cs_n <= 1'b0;
    for (int k = len - 1; k >= 0; k--) begin
      link2.si <= bits[k];
      repeat (8) @(posedge i_clk_sys);
      link2.sclk <= 1'b1;
      repeat (8) @(posedge i_clk_sys);
      link2.sclk <= 1'b0;
    end
    repeat (8) @(posedge i_clk_sys);
    link2.cs_n <= 1'b1;
    link2.si <= ~bits[0];
    repeat (12) @(posedge i_clk_sys);
  endtask : raw_frame
  initial begin
    wait (cycles == 95000);
    fails = fails + 1;
    close_out();
  end
  // ====================
  // Scenarios
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 8'h00;
    cmd_addr = 24'h000000;
    prot = 5'h00;
    link2.cs_n = 1'b1;
    link2.sclk = 1'b0;
    link2.si = 1'b0;
    i_srst = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    n = starts2;
    for (int i = 0; i < 3; i++) begin
      raw_frame(40'h0000000006, 8);
      raw_frame(f_bits[i], f_len[i]);
    end
    check(starts2 - n, 0);
    raw_frame(40'h0000000006, 8);
    raw_frame(40'h0000000060, 8);
    check(starts2 - n, 1);
    cmd(8'h52, 24'h12b456);
    check(wire_sr[31:0], {8'h52, 24'h12b456});
    check(nbits, 32);
    check({kind, busy, write_latch_flag}, {flash_erase_pkg::OPK_BLK32, 2'b10});
    check(base, 24'h128000);
    cmd(8'h05, 24'h000000);
    check(rsp_status[1:0], 2'b01);
    wait_idle();
    check({busy, write_latch_flag, link.cs_n, link.sclk}, 4'b0010);
    prot <= 5'h01;
    for (int i = 0; i < 4; i++) begin
      n = starts;
      cmd(prot_op[i], prot_addr[i]);
      check(starts - n, 0);
    end
    cmd(8'hd8, 24'h7effff);
    check(base, 24'h7e0000);
    wait_idle();
    prot <= 5'h00;
    for (int i = 2; i < 4; i++) begin
      cmd(prot_op[i], 24'h000000);
      check({kind, busy, write_latch_flag}, {flash_erase_pkg::OPK_CHIP, 2'b11});
      cmd(8'h75, 24'h000000);
      check({suspended_flag, busy}, 2'b01);
      cmd(8'h05, 24'h000000);
      check(rsp_status[0], 1'b1);
      wait_idle();
      check({busy, write_latch_flag, suspended_flag}, 3'b000);
    end
    cmd(8'h7a, 24'h000000);
    cmd(8'h75, 24'h000000);
    check({suspended_flag, busy}, 2'b00);
    for (int i = 0; i < 4; i++) begin
      cmd(sus_op[i], sus_addr[i]);
      cmd(8'h75, 24'h000000);
      check({suspended_flag, busy, kind}, {2'b10, flash_erase_pkg::OPK_NONE});
      n = starts;
      for (int j = 0; j < 4; j++) begin
        cmd((i == 0) ? 8'h02 : rej_op[j], sus_addr[i] ^ 24'h400000);
      end
      check({starts - n, suspended_flag, busy}, {32'h00000000, 2'b10});
      cmd(8'h7a, 24'h000000);
      check({suspended_flag, busy, kind}, {2'b01, sus_kind[i]});
      check(base, sus_base[i]);
      wait_idle();
    end
    close_out();
  end
endmodule : tb_top
`default_nettype wire
